// *** common/rx_port_map_pkg.sv ***
// package: offsets, field layout, reset values and carriers for the rx port map/stats bank
// assumes an i2c target elsewhere turns bus cycles into single-cycle rd/wr strobes
package rx_port_map_pkg;
   localparam int          NUM_PORTS          = 4;
   localparam logic [7:0]  PORT_SELECT_OFFSET = 8'h4c;
   localparam logic [7:0]  RAW10_ID_OFFSET    = 8'h70;
   localparam logic [7:0]  RAW12_CHANNEL_AND_TYPE_OFFSET    = 8'h71;
   localparam logic [7:0]  VC_REMAP_OFFSET    = 8'h72;
   localparam logic [7:0]  LINES_HIGH_OFFSET  = 8'h73;
   localparam logic [7:0]  LINES_LOW_OFFSET   = 8'h74;
   localparam logic [7:0]  WIDTH_HIGH_OFFSET  = 8'h75;
   localparam logic [7:0]  WIDTH_LOW_OFFSET   = 8'h76;
   localparam int          VC_MSB             = 7;
   localparam int          VC_LSB             = 6;
   localparam int          DT_MSB             = 5;
   localparam int          DT_LSB             = 0;
   localparam logic [5:0]  RAW12_DATA_TYPE_RESET     = 6'h2c;
   localparam logic [5:0]  RAW10_DT_RESET     = 6'h2b;
   localparam logic [7:0]  VC_REMAP_RESET     = 8'he4;
   localparam logic [15:0] STAT_RESET         = 16'h0000;

   typedef enum logic [1:0] {
      FMT_RESERVED, FMT_RAW12_LF, FMT_RAW12_HF, FMT_RAW10
   } input_format_e;

   // one incoming packet header / one outgoing packet header
   typedef struct packed {
      logic       valid;
      logic [1:0] vc;
      logic [5:0] dt;
   } pkt_hdr_s;

   // per-line and per-frame video markers from the receive datapath
   typedef struct packed {
      logic frame_end;
      logic line_end;
   } video_evt_s;
endpackage

// *** logic/rx_port_slice.sv ***
// rx_port_slice: one receive port's copy of the map registers and line statistics
// assumes register strobes are already decoded for this port and last one cycle
`timescale 1ns/1ps
`default_nettype none
module rx_port_slice
   import rx_port_map_pkg::*;
#(
   parameter logic [1:0] PORT_INDEX = 2'h0
) (
   input  wire logic          sys_clk,
   input  wire logic          rstn,
   input  wire logic          wr_en,
   input  wire logic          rd_en,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [7:0]    wr_data,
   output logic      [7:0]    rd_data,
   input  wire input_format_e input_format_select,
   input  wire logic          line_count_change_irq_enable,
   input  wire logic          line_length_change_irq_enable,
   input  wire pkt_hdr_s      pkt_in,
   input  wire video_evt_s    video_evt,
   input  wire logic [15:0]   line_pixels,
   output pkt_hdr_s           pkt_out,
   output logic               line_count_event,
   output logic               line_length_event
);
   logic [7:0]  raw10_reg, raw10_next, raw12_reg, raw12_next, remap_reg, remap_next;
   logic [15:0] run_lines_reg, run_lines_next, last_len_reg, last_len_next;
   logic [15:0] lines_reg, lines_next, width_reg, width_next;
   logic [7:0]  lines_lo_hold_reg, lines_lo_hold_next, width_lo_hold_reg, width_lo_hold_next;
   logic        lines_frozen_reg, lines_frozen_next, width_frozen_reg, width_frozen_next;
   logic        cnt_evt_next, len_evt_next;
   pkt_hdr_s    pkt_next;
   logic        rd_lines, rd_width;

   // register writes, counting, freeze and byte-latch logic
   always_comb begin
      raw10_next         = raw10_reg;
      raw12_next         = raw12_reg;
      remap_next         = remap_reg;
      run_lines_next     = run_lines_reg;
      last_len_next      = last_len_reg;
      lines_next         = lines_reg;
      width_next         = width_reg;
      lines_lo_hold_next = lines_lo_hold_reg;
      width_lo_hold_next = width_lo_hold_reg;
      lines_frozen_next  = lines_frozen_reg;
      width_frozen_next  = width_frozen_reg;
      cnt_evt_next       = 1'b0;
      len_evt_next       = 1'b0;
      rd_lines           = rd_en && (reg_addr == LINES_HIGH_OFFSET || reg_addr == LINES_LOW_OFFSET);
      rd_width           = rd_en && (reg_addr == WIDTH_HIGH_OFFSET || reg_addr == WIDTH_LOW_OFFSET);
      if (wr_en) begin
         unique case (reg_addr)
            RAW10_ID_OFFSET: raw10_next = wr_data;
            RAW12_CHANNEL_AND_TYPE_OFFSET: raw12_next = wr_data;
            VC_REMAP_OFFSET: remap_next = wr_data;
            default: ;
         endcase
      end
      // high-byte read captures the low byte for a coherent pair
      if (rd_en && reg_addr == LINES_HIGH_OFFSET)
         lines_lo_hold_next = lines_reg[7:0];
      if (rd_en && reg_addr == WIDTH_HIGH_OFFSET)
         width_lo_hold_next = width_reg[7:0];
      // a read unfreezes; a same-cycle frame end still updates after it
      if (rd_lines)
         lines_frozen_next = 1'b0;
      if (rd_width)
         width_frozen_next = 1'b0;
      if (video_evt.line_end) begin
         run_lines_next = run_lines_reg + 16'h0001;
         last_len_next  = line_pixels;
      end
      if (video_evt.frame_end) begin
         run_lines_next = 16'h0000;
         if (!(lines_frozen_reg && !rd_lines)) begin
            lines_next = run_lines_reg;
            if (run_lines_reg != lines_reg) begin
               cnt_evt_next      = line_count_change_irq_enable;
               lines_frozen_next = line_count_change_irq_enable;
            end
         end
         if (!(width_frozen_reg && !rd_width)) begin
            width_next = last_len_reg;
            if (last_len_reg != width_reg) begin
               len_evt_next      = line_length_change_irq_enable;
               width_frozen_next = line_length_change_irq_enable;
            end
         end
      end
   end

   // vc/dt substitution by input format; reserved format remaps the vc and passes the dt unchanged
   always_comb begin
      pkt_next = pkt_in;
      unique case (input_format_select)
         FMT_RAW12_LF, FMT_RAW12_HF: begin
            pkt_next.vc = raw12_reg[VC_MSB:VC_LSB];
            pkt_next.dt = raw12_reg[DT_MSB:DT_LSB];
         end
         FMT_RAW10: begin
            pkt_next.vc = raw10_reg[VC_MSB:VC_LSB];
            pkt_next.dt = raw10_reg[DT_MSB:DT_LSB];
         end
         FMT_RESERVED: begin
            // csi-2 pass-through port: remap the incoming vc id
            pkt_next.vc = remap_reg[{pkt_in.vc, 1'b0} +: 2];
         end
      endcase
   end

   // read mux, low bytes return the latched copy
   always_comb begin
      unique case (reg_addr)
         RAW10_ID_OFFSET:   rd_data = raw10_reg;
         RAW12_CHANNEL_AND_TYPE_OFFSET:   rd_data = raw12_reg;
         VC_REMAP_OFFSET:   rd_data = remap_reg;
         LINES_HIGH_OFFSET: rd_data = lines_reg[15:8];
         LINES_LOW_OFFSET:  rd_data = lines_lo_hold_reg;
         WIDTH_HIGH_OFFSET: rd_data = width_reg[15:8];
         WIDTH_LOW_OFFSET:  rd_data = width_lo_hold_reg;
         default:           rd_data = 8'h00;
      endcase
   end

   // register stage
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         raw10_reg         <= {PORT_INDEX, RAW10_DT_RESET};
         raw12_reg         <= {PORT_INDEX, RAW12_DATA_TYPE_RESET};
         remap_reg         <= VC_REMAP_RESET;
         run_lines_reg     <= STAT_RESET;
         last_len_reg      <= STAT_RESET;
         lines_reg         <= STAT_RESET;
         width_reg         <= STAT_RESET;
         lines_lo_hold_reg <= STAT_RESET[7:0];
         width_lo_hold_reg <= STAT_RESET[7:0];
         lines_frozen_reg  <= 1'b0;
         width_frozen_reg  <= 1'b0;
         line_count_event  <= 1'b0;
         line_length_event <= 1'b0;
         pkt_out           <= '0;
      end else begin
         raw10_reg         <= raw10_next;
         raw12_reg         <= raw12_next;
         remap_reg         <= remap_next;
         run_lines_reg     <= run_lines_next;
         last_len_reg      <= last_len_next;
         lines_reg         <= lines_next;
         width_reg         <= width_next;
         lines_lo_hold_reg <= lines_lo_hold_next;
         width_lo_hold_reg <= width_lo_hold_next;
         lines_frozen_reg  <= lines_frozen_next;
         width_frozen_reg  <= width_frozen_next;
         line_count_event  <= cnt_evt_next;
         line_length_event <= len_evt_next;
         pkt_out           <= pkt_next;
      end
   end

   AST_RAW12_TAG: assert property (@(posedge sys_clk) disable iff (!rstn)
      (pkt_in.valid && (input_format_select == FMT_RAW12_LF
         || input_format_select == FMT_RAW12_HF))
      |=> pkt_out.vc == $past(raw12_reg[VC_MSB:VC_LSB]) && pkt_out.dt == $past(raw12_reg[DT_MSB:DT_LSB]))
      else $error("raw12 header not substituted");
   AST_REMAP: assert property (@(posedge sys_clk) disable iff (!rstn)
      (input_format_select == FMT_RESERVED)
      |=> pkt_out.vc == $past(remap_reg[{pkt_in.vc, 1'b0} +: 2]) && pkt_out.dt == $past(pkt_in.dt))
      else $error("vc remap wrong");
   AST_RESET_VC: assert property (@(posedge sys_clk)
      $rose(rstn) |-> raw12_reg == {PORT_INDEX, RAW12_DATA_TYPE_RESET} && remap_reg == VC_REMAP_RESET)
      else $error("map reset value wrong");
   AST_LINES_UPDATE: assert property (@(posedge sys_clk) disable iff (!rstn)
      (video_evt.frame_end && !lines_frozen_reg) |=> lines_reg == $past(run_lines_reg))
      else $error("line count not reported at frame end");
   AST_LINES_FROZEN: assert property (@(posedge sys_clk) disable iff (!rstn)
      (lines_frozen_reg && !rd_lines) |=> $stable(lines_reg))
      else $error("frozen line count changed");
   AST_LINES_LATCH: assert property (@(posedge sys_clk) disable iff (!rstn)
      (rd_en && reg_addr == LINES_HIGH_OFFSET) ##1 (rd_en && reg_addr == LINES_LOW_OFFSET)
      |-> rd_data == $past(lines_reg[7:0]))
      else $error("line count low byte not coherent");
   AST_WIDTH_UPDATE: assert property (@(posedge sys_clk) disable iff (!rstn)
      (video_evt.frame_end && !width_frozen_reg) |=> width_reg == $past(last_len_reg))
      else $error("line length not last line of frame");
   AST_WIDTH_FROZEN: assert property (@(posedge sys_clk) disable iff (!rstn)
      (width_frozen_reg && !rd_width) |=> $stable(width_reg))
      else $error("frozen line length changed");
   AST_WIDTH_LATCH: assert property (@(posedge sys_clk) disable iff (!rstn)
      (rd_en && reg_addr == WIDTH_HIGH_OFFSET) |=> width_lo_hold_reg == $past(width_reg[7:0]))
      else $error("line length low byte not latched");
   AST_CNT_EVENT: assert property (@(posedge sys_clk) disable iff (!rstn)
      line_count_event |-> $past(line_count_change_irq_enable) && lines_frozen_reg)
      else $error("line count event without enable");
endmodule
`default_nettype wire

// *** logic/rx_port_map_bank.sv ***
// rx_port_map_bank: four per-port copies of the vc map and line statistics registers
// assumes the i2c target gives byte strobes, and port select lives in the shared page
`timescale 1ns/1ps
`default_nettype none
module rx_port_map_bank
   import rx_port_map_pkg::*;
(
   input  wire logic                     sys_clk,
   input  wire logic                     rstn,
   input  wire logic                     wr_en,
   input  wire logic                     rd_en,
   input  wire logic [7:0]               reg_addr,
   input  wire logic [7:0]               wr_data,
   output logic      [7:0]               rd_data,
   input  wire logic [NUM_PORTS-1:0]     port_select,
   input  wire input_format_e [NUM_PORTS-1:0] input_format_select,
   input  wire logic [NUM_PORTS-1:0]     line_count_change_irq_enable,
   input  wire logic [NUM_PORTS-1:0]     line_length_change_irq_enable,
   input  wire pkt_hdr_s [NUM_PORTS-1:0] pkt_in,
   input  wire video_evt_s [NUM_PORTS-1:0] video_evt,
   input  wire logic [NUM_PORTS-1:0][15:0] line_pixels,
   output pkt_hdr_s [NUM_PORTS-1:0]      pkt_out,
   output logic [NUM_PORTS-1:0]          line_count_event,
   output logic [NUM_PORTS-1:0]          line_length_event
);
   logic [NUM_PORTS-1:0][7:0] port_rd;
   logic [7:0]                rd_next;
   logic [7:0]                rd_data_reg;
   logic [NUM_PORTS-1:0]      rd_pick;

   // one slice per port; writes may fan to several selected ports, reads take the lowest
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      rx_port_slice #(.PORT_INDEX(2'(p))) u_slice (
         .sys_clk                       (sys_clk),
         .rstn                          (rstn),
         .wr_en                         (wr_en && port_select[p]),
         .rd_en                         (rd_en && rd_pick[p]),
         .reg_addr                      (reg_addr),
         .wr_data                       (wr_data),
         .rd_data                       (port_rd[p]),
         .input_format_select           (input_format_select[p]),
         .line_count_change_irq_enable  (line_count_change_irq_enable[p]),
         .line_length_change_irq_enable (line_length_change_irq_enable[p]),
         .pkt_in                        (pkt_in[p]),
         .video_evt                     (video_evt[p]),
         .line_pixels                   (line_pixels[p]),
         .pkt_out                       (pkt_out[p]),
         .line_count_event              (line_count_event[p]),
         .line_length_event             (line_length_event[p])
      );
   end

   // read select: lowest selected port answers; a one-hot pick keeps side effects to that
   // port even when two selected ports happen to hold the same byte
   always_comb begin
      rd_next = 8'h00;
      rd_pick = '0;
      for (int p = NUM_PORTS - 1; p >= 0; p--) begin
         if (port_select[p]) begin
            rd_next    = port_rd[p];
            rd_pick    = '0;
            rd_pick[p] = 1'b1;
         end
      end
   end

   // read data registered so it stands after the strobe
   always_ff @(posedge sys_clk) begin
      if (!rstn)
         rd_data_reg <= 8'h00;
      else if (rd_en)
         rd_data_reg <= rd_next;
   end
   assign rd_data = rd_data_reg;

   AST_PORT_ROUTE: assert property (@(posedge sys_clk) disable iff (!rstn)
      (rd_en && port_select == 4'h4) |=> rd_data == $past(port_rd[2]))
      else $error("read not routed to selected port");
endmodule
`default_nettype wire

// *** verif/video_source_model.sv ***
// video_source_model: far-side camera stream for one receive port, lines then a frame end
// assumes the bench raises go at a falling edge and holds it until done is seen
`timescale 1ns/1ps
`default_nettype none
module video_source_model
   import rx_port_map_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        go,
   input  wire logic [15:0] n_lines,
   input  wire logic [15:0] len_last,
   input  wire logic [3:0]  gap,
   output var video_evt_s   evt,
   output var logic [15:0]  pix,
   output var logic         done
);
   int i;
   // driven on falling edges; the length bus is inverted once released so stale values never match
   initial begin
      evt = '0;
      pix = 16'h0000;
      done = 1'b0;
      forever begin
         @(negedge sys_clk);
         if (go === 1'b1 && rstn === 1'b1 && done === 1'b0) begin
            for (i = 1; i <= int'(n_lines); i++) begin
               evt.line_end = 1'b1;
               pix = (i == int'(n_lines)) ? len_last : ~len_last; // earlier lines differ on purpose
               @(negedge sys_clk);
               // back-to-back lines keep the strobe up instead of dropping and raising it at once
               if (gap != 4'h0 || i == int'(n_lines)) begin
                  evt.line_end = 1'b0;
                  pix = ~pix;
               end
               repeat (gap) @(negedge sys_clk); // slow source idles between lines
            end
            evt.frame_end = 1'b1;
            @(negedge sys_clk);
            evt.frame_end = 1'b0;
            done = 1'b1;
         end else if (go !== 1'b1) begin
            done = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** verif/rx_port_map_bank_test.sv ***
// rx_port_map_bank_test: directed scenarios for the per-port map and line statistics bank
// assumes one 40 MHz clock; the video source feeds port 0 only, other ports stay idle
`timescale 1ns/1ps
`default_nettype none
module rx_port_map_bank_test
   import rx_port_map_pkg::*;
;
   logic                          sys_clk, rstn, wr_en, rd_en, go, done;
   logic [7:0]                    reg_addr, wr_data, rd_data, d;
   logic [NUM_PORTS-1:0]          port_select, cnt_ie, len_ie, line_count_event, line_length_event;
   input_format_e [NUM_PORTS-1:0] fmt;
   pkt_hdr_s [NUM_PORTS-1:0]      pkt_in, pkt_out;
   video_evt_s [NUM_PORTS-1:0]    video_evt;
   video_evt_s                    src_evt;
   logic [15:0]                   n_lines, len_last, src_pix;
   logic [3:0]                    gap;
   int                            n_fail, comparisons, n_cevt, n_levt, p, a;

   rx_port_map_bank u_rx_port_map_bank (.sys_clk(sys_clk), .rstn(rstn), .wr_en(wr_en),
      .rd_en(rd_en), .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data),
      .port_select(port_select), .input_format_select(fmt),
      .line_count_change_irq_enable(cnt_ie), .line_length_change_irq_enable(len_ie),
      .pkt_in(pkt_in), .video_evt(video_evt), .line_pixels({NUM_PORTS{src_pix}}),
      .pkt_out(pkt_out), .line_count_event(line_count_event),
      .line_length_event(line_length_event));
   video_source_model u_video_source_model (.sys_clk(sys_clk), .rstn(rstn), .go(go),
      .n_lines(n_lines), .len_last(len_last), .gap(gap), .evt(src_evt), .pix(src_pix),
      .done(done));

   // only port 0 sees video, so the other ports' statistics must stay put
   always_comb begin
      video_evt = '0;
      video_evt[0] = src_evt;
   end
   // event pulses last one cycle, so they are counted on every rising edge
   always @(posedge sys_clk) begin
      if (rstn === 1'b1 && line_count_event[0] === 1'b1) n_cevt++;
      if (rstn === 1'b1 && line_length_event[0] === 1'b1) n_levt++;
   end
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      @(negedge sys_clk);
      wr_en = 1'b1;
      reg_addr = adr;
      wr_data = dat;
      @(negedge sys_clk);
      wr_en = 1'b0;
   endtask
   // rd_data is registered at the edge that takes the strobe, so it is settled one negedge later
   task automatic rd(input logic [7:0] adr, output logic [7:0] q);
      @(negedge sys_clk);
      rd_en = 1'b1;
      reg_addr = adr;
      @(negedge sys_clk);
      rd_en = 1'b0;
      q = rd_data;
   endtask
   task automatic rdc(input logic [7:0] adr, input logic [7:0] exp);
      rd(adr, d);
      check({8'h00, d}, {8'h00, exp});
   endtask
   // high byte then low byte on back-to-back cycles, the low byte comes from the latch
   task automatic rd16(input logic [7:0] adr, input logic [15:0] exp);
      logic [7:0] hi;
      @(negedge sys_clk);
      rd_en = 1'b1;
      reg_addr = adr;
      @(negedge sys_clk);
      hi = rd_data;
      reg_addr = adr + 8'h01;
      @(negedge sys_clk);
      rd_en = 1'b0;
      d = rd_data;
      check({hi, d}, exp);
   endtask
   task automatic pkt(input logic [1:0] vc, input logic [8:0] exp);
      @(negedge sys_clk);
      pkt_in[0] = {1'b1, vc, 6'h12};
      @(negedge sys_clk);
      pkt_in[0] = '0;
      check({7'h00, pkt_out[0]}, {7'h00, exp});
   endtask
   // bounded wait on the source; a hang is a mismatch and ends the run
   task automatic frame(input logic [15:0] n, input logic [15:0] last, input logic [3:0] g);
      int i;
      @(negedge sys_clk);
      n_lines = n;
      len_last = last;
      gap = g;
      go = 1'b1;
      for (i = 0; i < 4000 && done !== 1'b1; i++) @(negedge sys_clk);
      if (i == 4000) begin
         n_fail++;
         tally_and_finish();
      end
      go = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask

   initial begin
      {rstn, wr_en, rd_en, go, reg_addr, wr_data, cnt_ie, len_ie} = '0;
      {pkt_in, n_lines, len_last, gap} = '0;
      port_select = 4'h1;
      fmt = {NUM_PORTS{FMT_RESERVED}};
      {n_fail, comparisons, n_cevt, n_levt} = '0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      rstn = 1'b1;
      // reset contents of every port's copy, plus an unmapped offset
      for (p = 0; p < NUM_PORTS; p++) begin
         port_select = 4'(1 << p);
         rdc(8'h70, {2'(p), RAW10_DT_RESET});
         rdc(8'h71, {2'(p), RAW12_DATA_TYPE_RESET});
         rdc(8'h72, VC_REMAP_RESET);
         for (a = 8'h73; a <= 8'h77; a++) rdc(8'(a), 8'h00);
      end
      // each port keeps its own remap table; statistics ignore writes
      for (p = 0; p < NUM_PORTS; p++) begin
         port_select = 4'(1 << p);
         wr(8'h72, 8'(8'h30 + p));
         wr(8'h73, 8'hff);
      end
      for (p = 0; p < NUM_PORTS; p++) begin
         port_select = 4'(1 << p);
         rdc(8'h72, 8'(8'h30 + p));
         rdc(8'h73, 8'h00);
      end
      // csi-2 mode with a reversing map, then both raw12 modes and raw10
      port_select = 4'h1;
      wr(8'h72, 8'h1b);
      for (p = 0; p < 4; p++) pkt(2'(p), {1'b1, 2'(3 - p), 6'h12});
      wr(8'h71, 8'h95);
      fmt[0] = FMT_RAW12_LF;
      pkt(2'h1, {1'b1, 2'h2, 6'h15});
      fmt[0] = FMT_RAW12_HF;
      pkt(2'h3, {1'b1, 2'h2, 6'h15});
      fmt[0] = FMT_RAW10;
      pkt(2'h3, {1'b1, 2'h0, RAW10_DT_RESET});
      // statistics with enables off: every frame updates, no events
      frame(16'h0003, 16'h1234, 4'h0);
      rd16(8'h73, 16'h0003);
      rd16(8'h75, 16'h1234);
      frame(16'h0004, 16'h0056, 4'h2);
      rd16(8'h73, 16'h0004);
      rd16(8'h75, 16'h0056);
      check(16'(n_cevt + n_levt), 16'h0000);
      // enables on: values freeze until read, low byte comes from the latch
      cnt_ie[0] = 1'b1;
      len_ie[0] = 1'b1;
      frame(16'h0102, 16'h0a0b, 4'h0);
      check(16'(n_cevt * 16 + n_levt), 16'h0011);
      frame(16'h0005, 16'h0030, 4'h0);
      rdc(8'h73, 8'h01);
      frame(16'h0007, 16'h0040, 4'h0);
      rdc(8'h74, 8'h02);
      rd16(8'h73, 16'h0007);
      rd16(8'h75, 16'h0a0b);
      frame(16'h0002, 16'h0050, 4'h1);
      rd16(8'h75, 16'h0050);
      check(16'(n_cevt * 16 + n_levt), 16'h0032);
      // an unchanged frame after both reads raises no event
      rd16(8'h73, 16'h0002);
      frame(16'h0002, 16'h0050, 4'h0);
      check(16'(n_cevt * 16 + n_levt), 16'h0032);
      port_select = 4'h2;
      rd16(8'h73, 16'h0000);
      tally_and_finish();
   end
endmodule
`default_nettype wire
